// file: verilog/anpx_defines.svh
// Offsets, field positions, reset values for the page-exchange registers.
// Assumes a 32-bit AXI4-Lite bus; byte address is four times the index.
`ifndef ANPX_DEFINES_SVH
`define ANPX_DEFINES_SVH

`define ANPX_IDX_PARTNER_ABILITY 5'h05
`define ANPX_IDX_EXPANSION 5'h06
`define ANPX_IDX_NP_TRANSMIT 5'h07
`define ANPX_IDX_PARTNER_NP 5'h08
`define ANPX_IDX_GIG_CONTROL 5'h09
`define ANPX_IDX_MODE_CONFIG 5'h10
`define ANPX_IDX_PAGE_SELECT 5'h16

`define ANPX_NP_TX_RESET 16'h2001
`define ANPX_NP_TX_WRITE_MASK 16'hB7FF
`define ANPX_NP_TOGGLE_BIT 11
`define ANPX_GIG_CTRL_RESET 3'h3
`define ANPX_MEDIA_MODE_RESET 3'h3

`define ANPX_EXP_PD_FAULT 4
`define ANPX_EXP_PARTNER_NP 3
`define ANPX_EXP_LOCAL_NP 2
`define ANPX_EXP_PAGE_RX 1
`define ANPX_EXP_PARTNER_AN 0

`define ANPX_TEST_NORMAL 3'h0
`define ANPX_TEST_JITTER_MASTER 3'h2
`define ANPX_TEST_JITTER_SLAVE 3'h3

`define ANPX_RESP_OKAY 2'h0
`define ANPX_RESP_SLVERR 2'h2

`endif

// file: verilog/anpx_pkg.sv
// Types shared by the page-exchange register block.
// Assumes the negotiation core drives its events on the same clock.
package anpx_pkg;
	typedef enum logic [1:0] {FM_1000X, FM_SGMII, FM_100FX} anpx_fiber_mode_e;

	typedef struct packed {
		logic page_rx;
		logic base_page;
		logic [15:0] rx_word;
		logic link_fail;
		logic np_sent;
		logic partner_an_able;
		logic partner_np_able;
		logic pd_fault;
	} anpx_media_in_s;

	typedef struct packed {
		logic sw_reset;
		logic an_restart;
		logic power_up_exit;
	} anpx_ctrl_in_s;

	typedef struct packed {
		logic loaded;
		logic [15:0] word;
	} anpx_np_out_s;

	typedef struct packed {
		logic [2:0] test_mode;
		logic tx_clk_from_rx;
		logic ms_manual;
		logic ms_master;
		logic port_master;
	} anpx_gig_out_s;
endpackage

// file: verilog/anpx_regs.sv
// Page-exchange register bank behind an AXI4-Lite slave.
// Assumes core event inputs are synchronous to aclk, one-cycle pulses.
// Function
// [RULE1] Fiber pause field reports received bits 8:7
// [RULE2] Fiber bits 6,5 give partner duplex ability
// [RULE3] Copper parallel-detect fault bit latches high
// [RULE4] Software ignores expansion until negotiation completes
// [RULE5] Expansion bit 2 always reads one
// [RULE6] Page-received bit latches until cleared
// [RULE7] Bits 0,3 show partner negotiation, next-page
// [RULE8] Fiber expansion bits meaningless in SGMII/100FX
// [RULE9] Next-page write sets page-loaded flag
// [RULE10] Link failure clears next-page transmit register
// [RULE11] Next-page transmit fields and reset values
// [RULE12] Partner next-page copies received word
// [RULE13] Copper next-page valid for modes 1,2,3,5
// [RULE14] Fiber next-page valid for modes 3,7
// [RULE15] Gigabit bits 15:13 select test mode
// [RULE16] Jitter tests take transmit clock from receive
// [RULE17] Negotiation restart clears test mode
// [RULE18] Software resets after leaving test mode
// [RULE19] Bit 12 manual, bit 11 master value
// [RULE20] Master/slave writes apply on listed events
// [RULE21] Port-type bit ignored under manual configuration
// [RULE22] Reserved expansion bits read zero
// [RULE23] Latched bits clear on read, set wins
// [RULE24] Toggle bit flips per sent next page; not flipped when a next-page write lands in the same cycle
//
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/100ps
`include "anpx_defines.svh"

module anpx_regs #(
	parameter int ADDR_W = 8
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire anpx_pkg::anpx_media_in_s copper_in,
	input wire anpx_pkg::anpx_media_in_s fiber_in,
	input wire anpx_pkg::anpx_ctrl_in_s ctrl_in,
	output anpx_pkg::anpx_np_out_s copper_np_out,
	output anpx_pkg::anpx_np_out_s fiber_np_out,
	output anpx_pkg::anpx_gig_out_s gig_out
);

	// Index 0 is copper, 1 is fiber
	anpx_pkg::anpx_media_in_s media [2];
	logic [15:0] np_tx_r [2];
	logic np_loaded_r [2];
	logic [15:0] partner_np_r [2];
	logic page_rx_r [2];
	logic partner_an_r [2];
	logic partner_np_able_r [2];
	logic pd_fault_r;
	logic [15:0] fx_ability_r;
	logic [5:0] gig_ctrl_r;
	logic [2:0] media_mode_r;
	anpx_pkg::anpx_fiber_mode_e fiber_mode_r;
	logic page_r;

	logic [ADDR_W-1:0] awaddr_r;
	logic aw_held_r;
	logic [15:0] wdata_r;
	logic [1:0] wstrb_r;
	logic w_held_r;
	logic do_write;
	logic do_read;
	logic [4:0] wr_idx;
	logic [4:0] rd_idx;
	logic [15:0] rd_data;
	logic rd_hit;
	logic [15:0] wr_val;
	logic clr_on_read [2];
	logic cu_np_valid;
	logic fx_np_valid;
	logic np_wr [2];
	logic gig_apply;

	assign media[0] = copper_in;
	assign media[1] = fiber_in;

	function automatic logic cu_valid(input logic [2:0] mode);
		cu_valid = (mode == 3'h1) || (mode == 3'h2) || (mode == 3'h3) || (mode == 3'h5);
	endfunction

	function automatic logic fx_valid(input logic [2:0] mode);
		fx_valid = (mode == 3'h3) || (mode == 3'h7);
	endfunction

	function automatic logic [4:0] reg_index(input logic [ADDR_W-1:0] addr);
		reg_index = addr[6:2];
	endfunction

	function automatic logic in_map(input logic [ADDR_W-1:0] addr);
		in_map = (addr[1:0] == 2'h0) && (addr[ADDR_W-1:2] < 32);
	endfunction

	assign cu_np_valid = cu_valid(media_mode_r); // [RULE13]
	assign fx_np_valid = fx_valid(media_mode_r); // [RULE14]

	// Write channel: address and data taken in either order
	assign do_write = aw_held_r && w_held_r && !s_axi_bvalid;
	assign wr_idx = reg_index(awaddr_r);
	assign wr_val = {wstrb_r[1] ? wdata_r[15:8] : 8'h00, wstrb_r[0] ? wdata_r[7:0] : 8'h00};

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_r <= 1'b0;
			w_held_r <= 1'b0;
			awaddr_r <= '0;
			wdata_r <= 16'h0000;
			wstrb_r <= 2'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `ANPX_RESP_OKAY;
		end else begin
			s_axi_awready <= !aw_held_r && !(s_axi_awvalid && s_axi_awready);
			s_axi_wready <= !w_held_r && !(s_axi_wvalid && s_axi_wready);
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_r <= 1'b1;
				awaddr_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_r <= 1'b1;
				wdata_r <= s_axi_wdata[15:0];
				wstrb_r <= s_axi_wstrb[1:0];
			end
			if (do_write) begin
				aw_held_r <= 1'b0;
				w_held_r <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= in_map(awaddr_r) ? `ANPX_RESP_OKAY : `ANPX_RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Write-only strobes decoded from the held address
	always_comb begin
		np_wr[0] = 1'b0;
		np_wr[1] = 1'b0;
		if (do_write && in_map(awaddr_r) && wr_idx == `ANPX_IDX_NP_TRANSMIT) begin
			if (!page_r) begin
				np_wr[0] = cu_np_valid;
			end else begin
				np_wr[1] = fx_np_valid;
			end
		end
	end

	// Read channel: one read at a time, data one cycle after address
	assign do_read = s_axi_arvalid && s_axi_arready;
	assign rd_idx = reg_index(s_axi_araddr);

	always_comb begin
		rd_data = 16'h0000;
		rd_hit = in_map(s_axi_araddr);
		if (rd_idx == `ANPX_IDX_PARTNER_ABILITY) begin
			if (page_r && fiber_mode_r == anpx_pkg::FM_1000X) begin
				rd_data = {fx_ability_r[15:5], 5'h00}; // [RULE1] [RULE2]
			end else if (page_r && fiber_mode_r == anpx_pkg::FM_SGMII) begin
				rd_data = {fx_ability_r[15:9], 9'h000}; // [RULE1] [RULE2]
			end
		end else if (rd_idx == `ANPX_IDX_EXPANSION) begin
			if (!page_r) begin
				rd_data[`ANPX_EXP_PD_FAULT] = pd_fault_r; // [RULE3]
				rd_data[`ANPX_EXP_PARTNER_NP] = partner_np_able_r[0]; // [RULE7]
				rd_data[`ANPX_EXP_LOCAL_NP] = 1'b1; // [RULE5]
				rd_data[`ANPX_EXP_PAGE_RX] = page_rx_r[0]; // [RULE6]
				rd_data[`ANPX_EXP_PARTNER_AN] = partner_an_r[0]; // [RULE7]
			end else begin
				rd_data[`ANPX_EXP_LOCAL_NP] = 1'b1; // [RULE5]
				rd_data[`ANPX_EXP_PAGE_RX] = page_rx_r[1]; // [RULE6]
				if (fiber_mode_r == anpx_pkg::FM_1000X) begin
					rd_data[`ANPX_EXP_PARTNER_NP] = partner_np_able_r[1]; // [RULE8]
					rd_data[`ANPX_EXP_PARTNER_AN] = partner_an_r[1]; // [RULE8]
				end
			end
			// Upper bits stay zero [RULE22]
		end else if (rd_idx == `ANPX_IDX_NP_TRANSMIT) begin
			if (!page_r && cu_np_valid) begin
				rd_data = np_tx_r[0]; // [RULE13]
			end else if (page_r && fx_np_valid) begin
				rd_data = np_tx_r[1]; // [RULE14]
			end
		end else if (rd_idx == `ANPX_IDX_PARTNER_NP) begin
			if (!page_r && cu_np_valid) begin
				rd_data = partner_np_r[0]; // [RULE13]
			end else if (page_r && fx_np_valid) begin
				rd_data = partner_np_r[1]; // [RULE14]
			end
		end else if (rd_idx == `ANPX_IDX_GIG_CONTROL) begin
			if (!page_r) begin
				rd_data = {gig_ctrl_r, 10'h000};
			end
		end else if (rd_idx == `ANPX_IDX_MODE_CONFIG) begin
			rd_data = {10'h000, 2'(fiber_mode_r), 1'b0, media_mode_r};
		end else if (rd_idx == `ANPX_IDX_PAGE_SELECT) begin
			rd_data = {15'h0000, page_r};
		end
	end

	// Latched flags of the page being read clear as they are returned
	assign clr_on_read[0] = do_read && rd_hit && !page_r && rd_idx == `ANPX_IDX_EXPANSION;
	assign clr_on_read[1] = do_read && rd_hit && page_r && rd_idx == `ANPX_IDX_EXPANSION;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `ANPX_RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !do_read;
			if (do_read) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= {16'h0000, rd_data};
				s_axi_rresp <= rd_hit ? `ANPX_RESP_OKAY : `ANPX_RESP_SLVERR;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// Page select and media mode configuration
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			page_r <= 1'b0;
			media_mode_r <= `ANPX_MEDIA_MODE_RESET;
			fiber_mode_r <= anpx_pkg::FM_1000X;
		end else if (do_write && in_map(awaddr_r)) begin
			if (wr_idx == `ANPX_IDX_PAGE_SELECT) begin
				page_r <= wr_val[0];
			end else if (wr_idx == `ANPX_IDX_MODE_CONFIG) begin
				media_mode_r <= wr_val[2:0];
				// Unused encoding falls back to 1000BASE-X
				if (wr_val[5:4] == 2'h1) begin
					fiber_mode_r <= anpx_pkg::FM_SGMII;
				end else if (wr_val[5:4] == 2'h2) begin
					fiber_mode_r <= anpx_pkg::FM_100FX;
				end else begin
					fiber_mode_r <= anpx_pkg::FM_1000X;
				end
			end
		end
	end

	// Next-page transmit, loaded flag and toggle per media
	always_ff @(posedge aclk) begin
		for (int m = 0; m < 2; m++) begin
			if (!aresetn) begin
				np_tx_r[m] <= `ANPX_NP_TX_RESET; // [RULE11]
				np_loaded_r[m] <= 1'b0;
			end else if (ctrl_in.sw_reset) begin
				np_tx_r[m] <= `ANPX_NP_TX_RESET; // [RULE11]
				np_loaded_r[m] <= 1'b0;
			end else if (media[m].link_fail) begin
				// Link loss beats a same-cycle write
				np_tx_r[m] <= 16'h0000; // [RULE10]
				np_loaded_r[m] <= 1'b0;
			end else begin
				if (np_wr[m]) begin
					np_tx_r[m] <= (wr_val & `ANPX_NP_TX_WRITE_MASK)
						| (np_tx_r[m] & ~`ANPX_NP_TX_WRITE_MASK); // [RULE11]
					np_loaded_r[m] <= 1'b1; // [RULE9]
				end else if (media[m].np_sent) begin
					np_loaded_r[m] <= 1'b0;
				end
				if (media[m].np_sent && !np_wr[m]) begin
					np_tx_r[m][`ANPX_NP_TOGGLE_BIT] <= !np_tx_r[m][`ANPX_NP_TOGGLE_BIT]; // [RULE24]
				end
			end
		end
	end

	// Received words and latched status
	always_ff @(posedge aclk) begin
		for (int m = 0; m < 2; m++) begin
			if (!aresetn || ctrl_in.sw_reset) begin
				partner_np_r[m] <= 16'h0000; // [RULE12]
				page_rx_r[m] <= 1'b0;
				partner_an_r[m] <= 1'b0;
				partner_np_able_r[m] <= 1'b0;
			end else begin
				if (media[m].page_rx && !media[m].base_page) begin
					partner_np_r[m] <= media[m].rx_word; // [RULE12]
				end
				partner_an_r[m] <= media[m].partner_an_able; // [RULE7]
				partner_np_able_r[m] <= media[m].partner_np_able; // [RULE7]
				// 100BASE-FX pages never raise the fiber flag
				if (media[m].page_rx && !(m == 1 && fiber_mode_r == anpx_pkg::FM_100FX)) begin
					page_rx_r[m] <= 1'b1; // [RULE6] [RULE23]
				end else if (clr_on_read[m]) begin
					page_rx_r[m] <= 1'b0; // [RULE23]
				end
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || ctrl_in.sw_reset) begin
			pd_fault_r <= 1'b0;
			fx_ability_r <= 16'h0000;
		end else begin
			if (copper_in.pd_fault) begin
				pd_fault_r <= 1'b1; // [RULE3] [RULE23]
			end else if (clr_on_read[0]) begin
				pd_fault_r <= 1'b0; // [RULE23]
			end
			if (fiber_in.page_rx && fiber_in.base_page) begin
				fx_ability_r <= fiber_in.rx_word; // [RULE1] [RULE2]
			end
		end
	end

	// Gigabit control: stored bits, master/slave bits applied on trigger events
	assign gig_apply = ctrl_in.sw_reset || ctrl_in.an_restart
		|| ctrl_in.power_up_exit || copper_in.link_fail; // [RULE20]

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			gig_ctrl_r <= {`ANPX_TEST_NORMAL, `ANPX_GIG_CTRL_RESET};
		end else begin
			if (do_write && in_map(awaddr_r) && !page_r && wr_idx == `ANPX_IDX_GIG_CONTROL) begin
				gig_ctrl_r <= wr_val[15:10]; // [RULE15] [RULE19]
			end
			// Restart wins over a same-cycle test mode write
			if (ctrl_in.an_restart) begin
				gig_ctrl_r[5:3] <= `ANPX_TEST_NORMAL; // [RULE17]
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			gig_out.ms_manual <= 1'b0;
			gig_out.ms_master <= 1'b1;
			gig_out.port_master <= 1'b1;
		end else if (gig_apply) begin
			gig_out.ms_manual <= gig_ctrl_r[2]; // [RULE19] [RULE20]
			gig_out.ms_master <= gig_ctrl_r[1]; // [RULE19] [RULE20]
			// Manual setting overrides the port preference
			gig_out.port_master <= gig_ctrl_r[2] ? gig_ctrl_r[1] : gig_ctrl_r[0]; // [RULE21]
		end
	end

	// Test mode acts at once; software resets after leaving it
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			gig_out.test_mode <= `ANPX_TEST_NORMAL;
			gig_out.tx_clk_from_rx <= 1'b0;
		end else begin
			gig_out.test_mode <= gig_ctrl_r[5:3]; // [RULE15] [RULE18]
			gig_out.tx_clk_from_rx <= (gig_ctrl_r[5:3] == `ANPX_TEST_JITTER_MASTER)
				|| (gig_ctrl_r[5:3] == `ANPX_TEST_JITTER_SLAVE); // [RULE16]
		end
	end

	// Core-facing next-page outputs, loaded flags gated by media validity
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			copper_np_out <= '0;
			fiber_np_out <= '0;
		end else begin
			copper_np_out.word <= np_tx_r[0];
			copper_np_out.loaded <= np_loaded_r[0] && cu_np_valid; // [RULE13]
			fiber_np_out.word <= np_tx_r[1];
			fiber_np_out.loaded <= np_loaded_r[1] && fx_np_valid; // [RULE14]
		end
	end

endmodule

// file: tb/anpx_regs_assertions.sv
// Checker on the page-exchange register bank ports.
// Assumes the bench keeps the bus idle around core events.
`timescale 1ns/100ps
module anpx_regs_assertions (
	input wire logic aclk,
	input wire logic aresetn,
	input wire anpx_pkg::anpx_media_in_s copper_in,
	input wire anpx_pkg::anpx_media_in_s fiber_in,
	input wire anpx_pkg::anpx_ctrl_in_s ctrl_in,
	input wire anpx_pkg::anpx_np_out_s copper_np_out,
	input wire anpx_pkg::anpx_np_out_s fiber_np_out,
	input wire anpx_pkg::anpx_gig_out_s gig_out
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Events that may move the master/slave outputs
	wire logic apply_ev = ctrl_in.sw_reset | ctrl_in.an_restart | ctrl_in.power_up_exit
		| copper_in.link_fail;
	a_jitter_clock: assert property (
		gig_out.tx_clk_from_rx == (gig_out.test_mode inside {3'h2, 3'h3}))
		else $error("transmit clock source wrong");
	a_port_manual: assert property (
		gig_out.ms_manual |-> gig_out.port_master == gig_out.ms_master)
		else $error("port type not ignored under manual");
	a_restart_clear: assert property (
		$rose(ctrl_in.an_restart) |-> ##2 gig_out.test_mode == 3'h0)
		else $error("restart kept test mode");
	a_link_clear: assert property (
		copper_in.link_fail |-> ##2 copper_np_out == '0)
		else $error("copper link fail kept next page");
	a_fiber_clear: assert property (
		fiber_in.link_fail ##1 1'b1 |-> ##1 fiber_np_out == '0)
		else $error("fiber link fail kept next page");
	a_toggle_flip: assert property (
		copper_in.np_sent && !copper_in.link_fail |-> ##2 !copper_np_out.loaded
		&& copper_np_out.word[11] != $past(copper_np_out.word[11]))
		else $error("toggle bit did not flip");
	a_swreset_np: assert property (
		ctrl_in.sw_reset |-> ##2 copper_np_out.word == 16'h2001
		&& fiber_np_out.word == 16'h2001)
		else $error("next page not back to reset value");
	a_ms_apply: assert property (
		!$stable({gig_out.ms_manual, gig_out.ms_master, gig_out.port_master})
		|-> $past(apply_ev))
		else $error("master/slave moved without event");
	c_jitter: cover property (gig_out.tx_clk_from_rx);
	c_loaded: cover property (copper_np_out.loaded ##1 copper_in.np_sent);
	c_manual: cover property ($rose(gig_out.ms_manual));
endmodule

bind anpx_regs anpx_regs_assertions anpx_regs_assertions_inst (.aclk(aclk),
	.aresetn(aresetn), .copper_in(copper_in), .fiber_in(fiber_in), .ctrl_in(ctrl_in),
	.copper_np_out(copper_np_out), .fiber_np_out(fiber_np_out), .gig_out(gig_out));

// file: tb/anpx_link_partner.sv
// Remote link partner model: received pages and link events.
// Assumes callers enter its task just after a rising edge.
`timescale 1ns/100ps
module anpx_link_partner (
	input wire logic aclk,
	output anpx_pkg::anpx_media_in_s copper_in,
	output anpx_pkg::anpx_media_in_s fiber_in
);
	initial begin
		copper_in = '0;
		fiber_in = '0;
	end
	// Kind 0 page, 1 link fail, 2 page sent, 3 fault
	task automatic hit(input bit fib, input int kind, input logic base,
		input logic [15:0] w, input logic [1:0] able);
		anpx_pkg::anpx_media_in_s m;
		m = fib ? fiber_in : copper_in;
		m.base_page = base;
		m.rx_word = w;
		{m.partner_an_able, m.partner_np_able} = able;
		{m.page_rx, m.link_fail, m.np_sent, m.pd_fault} = 4'h8 >> kind;
		if (fib)
			fiber_in <= m;
		else
			copper_in <= m;
		@(posedge aclk);
		// Word not held past its pulse; garble it
		m.rx_word = ~w;
		{m.page_rx, m.link_fail, m.np_sent, m.pd_fault} = 4'h0;
		if (fib)
			fiber_in <= m;
		else
			copper_in <= m;
		repeat (2) @(posedge aclk);
	endtask
endmodule

// file: tb/tb.sv
// Self-checking bench for the page-exchange register bank.
// Assumes the partner model drives media inputs; checker is bound.
`timescale 1ns/100ps
module tb;
	logic aclk, aresetn, awv, awr, wv, wr, bv, br, arv, arr, rv, rr;
	logic [7:0] awa, ara;
	logic [31:0] wd, rdat, got;
	logic [3:0] wst;
	logic [1:0] bresp, rresp, resp;
	logic [15:0] w;
	anpx_pkg::anpx_media_in_s copper_in, fiber_in;
	anpx_pkg::anpx_ctrl_in_s ctrl_in;
	anpx_pkg::anpx_np_out_s copper_np_out, fiber_np_out;
	anpx_pkg::anpx_gig_out_s gig_out;
	logic [2:0] ms;
	assign ms = {gig_out.ms_manual, gig_out.ms_master, gig_out.port_master};
	int n_fail, samples_checked;
	logic [7:0] ra [6] = '{8'h14, 8'h18, 8'h1c, 8'h20, 8'h24, 8'h40};
	logic [15:0] r0 [6] = '{16'h0000, 16'h0004, 16'h2001, 16'h0000, 16'h0c00, 16'h0003};

	anpx_regs anpx_regs_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
		.s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(wst),
		.s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
		.s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
		.s_axi_rdata(rdat), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr),
		.copper_in(copper_in), .fiber_in(fiber_in), .ctrl_in(ctrl_in),
		.copper_np_out(copper_np_out), .fiber_np_out(fiber_np_out), .gig_out(gig_out));
	anpx_link_partner anpx_link_partner_inst (.aclk(aclk), .copper_in(copper_in),
		.fiber_in(fiber_in));

	initial begin
		aclk = 0;
		forever #5 aclk = ~aclk;
	end

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] e);
		samples_checked++;
		if (seen !== e) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", nm, e, seen);
		end
	endtask

	task automatic wrap_up();
		$display("checked %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic guard(input int t);
		if (t >= 50) begin
			n_fail++;
			wrap_up();
		end
	endtask

	task automatic axi_wr(input logic [7:0] a, input logic [15:0] d);
		int t = 0;
		bit ao = 0;
		bit wo = 0;
		awa <= a;
		wd <= {16'h0000, d};
		awv <= 1'b1;
		wv <= 1'b1;
		br <= 1'b1;
		do begin
			@(posedge aclk);
			if (awv && awr) begin
				awv <= 1'b0;
				ao = 1;
			end
			if (wv && wr) begin
				wv <= 1'b0;
				wo = 1;
			end
		end while (!(ao && wo) && ++t < 50);
		do @(posedge aclk); while (!bv && ++t < 50);
		resp = bresp;
		guard(t);
		br <= 1'b0;
		@(posedge aclk);
	endtask

	task automatic axi_rd(input logic [7:0] a);
		int t = 0;
		ara <= a;
		arv <= 1'b1;
		rr <= 1'b1;
		do @(posedge aclk); while (!arr && ++t < 50);
		arv <= 1'b0;
		do @(posedge aclk); while (!rv && ++t < 50);
		guard(t);
		got = rdat;
		resp = rresp;
		rr <= 1'b0;
		@(posedge aclk);
	endtask

	task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
		axi_rd(a);
		chk(nm, got, e);
	endtask

	// Pulse order: software reset, restart, power-up exit
	task automatic ctl(input logic [2:0] v);
		ctrl_in <= v;
		@(posedge aclk);
		ctrl_in <= 3'h0;
		repeat (2) @(posedge aclk);
	endtask

	function automatic logic [31:0] ability(input int fm, input logic [15:0] v);
		if (fm == 0)
			return {16'h0000, v & 16'hffe0};
		if (fm == 1)
			return {16'h0000, v & 16'hfe00};
		return 32'h0000_0000;
	endfunction

	initial begin
		repeat (20000) @(posedge aclk);
		n_fail++;
		wrap_up();
	end

	initial begin
		{aresetn, awv, wv, br, arv, rr} = '0;
		{awa, ara, wd} = '0;
		wst = 4'h3;
		ctrl_in = '0;
		n_fail = 0;
		samples_checked = 0;
		w = 16'($urandom(32'ha49b_c152));
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		foreach (ra[i]) rchk("reset", ra[i], 32'(r0[i]));
		axi_rd(8'h19);
		chk("misaligned", 32'(resp), 32'h0000_0002);
		axi_wr(8'h1d, 16'hffff);
		chk("wr_misaligned", 32'(resp), 32'h0000_0002);
		chk("no_load", 32'(copper_np_out.loaded), 32'h0000_0000);
		// Next page load, send, link loss
		axi_wr(8'h1c, w);
		chk("bresp", 32'(resp), 32'h0000_0000);
		rchk("np_tx", 8'h1c, 32'(w & 16'hb7ff));
		chk("np_word", 32'(copper_np_out.word), 32'(w & 16'hb7ff));
		chk("loaded", 32'(copper_np_out.loaded), 32'h0000_0001);
		anpx_link_partner_inst.hit(0, 2, 0, 16'h0000, 2'h0);
		rchk("toggle", 8'h1c, 32'(w & 16'hb7ff | 16'h0800));
		chk("sent", 32'(copper_np_out.loaded), 32'h0000_0000);
		anpx_link_partner_inst.hit(0, 1, 0, 16'h0000, 2'h0);
		rchk("link_fail", 8'h1c, 32'h0000_0000);
		// Every media mode, both pages
		for (int m = 0; m < 8; m++) begin
			axi_wr(8'h40, 16'(m));
			for (int p = 0; p < 2; p++) begin
				axi_wr(8'h58, 16'(p));
				axi_wr(8'h1c, 16'h8005);
			end
			repeat (2) @(posedge aclk);
			chk("cu_loaded", 32'(copper_np_out.loaded), 32'(m inside {1, 2, 3, 5}));
			chk("fi_loaded", 32'(fiber_np_out.loaded), 32'(m inside {3, 7}));
			ctl(3'h4);
		end
		axi_wr(8'h58, 16'h0000);
		axi_wr(8'h40, 16'h0003);
		w = 16'($urandom);
		anpx_link_partner_inst.hit(0, 0, 0, w, 2'h3);
		anpx_link_partner_inst.hit(0, 3, 0, ~w, 2'h3);
		rchk("partner_np", 8'h20, 32'(w));
		// Read only once negotiation is done
		rchk("exp_set", 8'h18, 32'h0000_001f);
		rchk("exp_clear", 8'h18, 32'h0000_000d);
		axi_wr(8'h58, 16'h0001);
		for (int fm = 0; fm < 3; fm++) begin
			w = 16'($urandom);
			axi_wr(8'h40, 16'h0003 | 16'(fm << 4));
			anpx_link_partner_inst.hit(1, 0, 1, w, 2'h3);
			rchk("ability", 8'h14, ability(fm, w));
			rchk("fi_exp", 8'h18, {28'h0, fm == 0, 1'b1, fm != 2, fm == 0});
		end
		anpx_link_partner_inst.hit(1, 1, 0, 16'h0000, 2'h0);
		rchk("fi_link_fail", 8'h1c, 32'h0000_0000);
		axi_wr(8'h58, 16'h0000);
		axi_wr(8'h40, 16'h0003);
		// Test modes, then deferred master/slave settings
		for (int t = 0; t < 5; t++) begin
			axi_wr(8'h24, 16'(t << 13) | 16'h0c00);
			repeat (2) @(posedge aclk);
			chk("test_mode", 32'(gig_out.test_mode), 32'(t));
			chk("tx_clk", 32'(gig_out.tx_clk_from_rx), 32'(t inside {2, 3}));
		end
		axi_wr(8'h24, 16'h5400);
		repeat (2) @(posedge aclk);
		chk("ms_held", 32'(ms), 32'h0000_0003);
		ctl(3'h2);
		rchk("restart", 8'h24, 32'h0000_1400);
		chk("ms_manual", 32'(ms), 32'h0000_0004);
		axi_wr(8'h24, 16'h0800);
		ctl(3'h1);
		chk("ms_auto", 32'(ms), 32'h0000_0002);
		ctl(3'h4);
		wrap_up();
	end
endmodule
